/* hdl/led_status_serial.sv */
// LED driver core: serial shift path, status word, open-LED and overtemp flags, staggered PWM
//
// Operation
// - Status word shifts out only in grayscale mode
// - First shift rise after latch fall loads status
// - Status bits shift out each shift rise
// - Open flags refresh at 33rd pwm rise
// - Only channels on at 33rd edge checked
// - Open flag one means output below threshold
// - Overtemp flag follows die temperature detector
// - Overtemp sticky until shift fall after latch
// - Error output open-drain low on any flag
// - Inhibit masks open flags from error output
// - 33rd pwm fall switches open channels off
// - Four channel groups switched on in turn
// - Group k holds channels k, k+4, k+8, k+12
// - Stagger applies to turn-off edges too
// - Inhibit forces outputs off, clears counter
// - Brief enable gives shorter of count, window
// - Shift register output drives serial_out
// - Low select 192 bits, high 96 bits
// - Shift in MSB first, latch on rise
// - Counter saturates, channel on while nonzero count fits, off once saturated
`timescale 1ns/10ps
module led_status_serial
  import led_driver_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire ahb_req_t                      ahb_req,
  output ahb_rsp_t                           ahb_rsp,
  input  wire logic                          shift_clock,
  input  wire logic                          serial_in,
  input  wire logic                          latch_strobe,
  input  wire logic                          input_select,
  input  wire logic                          pwm_clock,
  input  wire logic                          output_inhibit,
  input  wire logic [CHANNELS-1:0]           open_detect,
  input  wire logic                          overtemp_detect,
  output logic                               serial_out,
  output logic                               error_flag_n_o,
  output logic                               error_flag_n_oe,
  output logic      [CHANNELS-1:0]           channel_output,
  output logic      [DC_SR_LEN-1:0]          dot_correction
);

  // Pin synchronisation
  localparam int PIN_COUNT = 6;
  localparam int P_SCLK    = 0;
  localparam int P_SIN     = 1;
  localparam int P_LATCH   = 2;
  localparam int P_SEL     = 3;
  localparam int P_PWM     = 4;
  localparam int P_INH     = 5;

  logic [PIN_COUNT-1:0] pin_level;
  logic [PIN_COUNT-1:0] pin_rise;
  logic [PIN_COUNT-1:0] pin_fall;
  logic [CHANNELS-1:0]  open_level;
  logic                 overtemp_level;

  pin_sync #(.WIDTH(PIN_COUNT)) u_ctrl_sync (
    .clk   (clk),
    .reset (reset),
    .pin   ({output_inhibit, pwm_clock, input_select, latch_strobe, serial_in, shift_clock}),
    .level (pin_level),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  // Analog detector levels are asynchronous to clk as well
  pin_sync #(.WIDTH(CHANNELS + 1)) u_detect_sync (
    .clk   (clk),
    .reset (reset),
    .pin   ({overtemp_detect, open_detect}),
    .level ({overtemp_level, open_level}),
    .rise  (),
    .fall  ()
  );

  logic shift_rise;
  logic shift_fall;
  logic sin_level;
  logic latch_rise;
  logic latch_fall;
  logic dc_mode;
  logic pwm_rise;
  logic pwm_fall;
  logic inhibit;

  assign shift_rise = pin_rise[P_SCLK];
  assign shift_fall = pin_fall[P_SCLK];
  assign sin_level  = pin_level[P_SIN];
  assign latch_rise = pin_rise[P_LATCH];
  assign latch_fall = pin_fall[P_LATCH];
  assign dc_mode    = pin_level[P_SEL];
  assign pwm_rise   = pin_rise[P_PWM];
  assign pwm_fall   = pin_fall[P_PWM];
  assign inhibit    = pin_level[P_INH];

  // Register file state
  logic [31:0]          ctrl_q;
  logic [GS_SR_LEN-1:0] shift_q;
  logic [GS_SR_LEN-1:0] gs_latch_q;
  logic [DC_SR_LEN-1:0] dc_latch_q;
  logic                 status_pending_q;
  logic                 tef_clear_pending_q;
  logic [CHANNELS-1:0]  open_flag_q;
  logic                 overtemp_flag_q;
  logic [CHANNELS-1:0]  off_mask_q;
  logic [GS_BITS-1:0]   gs_count_q;
  logic [CHANNELS-1:0]  raw_on_q;
  logic                 serial_out_q;
  logic                 error_q;

  status_word_t status_word;
  assign status_word.overtemp = overtemp_flag_q;
  assign status_word.open_led = open_flag_q;

  // Status load waits for the next shift rise after the latch falls
  always_ff @(posedge clk) begin
    if (reset) begin
      status_pending_q <= 1'b0;
    end else begin
      status_pending_q <= latch_fall | (status_pending_q & ~shift_rise);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tef_clear_pending_q <= 1'b0;
    end else begin
      tef_clear_pending_q <= latch_fall | (tef_clear_pending_q & ~shift_fall);
    end
  end

  // Input shift register, MSB first
  always_ff @(posedge clk) begin
    if (reset) begin
      shift_q <= '0;
    end else if (shift_rise) begin
      if (status_pending_q && !dc_mode) begin
        shift_q[GS_SR_LEN-1:STATUS_LSB] <= status_word;
      end else begin
        shift_q <= {shift_q[GS_SR_LEN-2:0], sin_level};
      end
    end
  end

  // Shift register length follows the selected mode
  always_ff @(posedge clk) begin
    if (reset) begin
      serial_out_q <= 1'b0;
    end else if (dc_mode) begin
      serial_out_q <= shift_q[DC_SR_LEN-1];
    end else begin
      serial_out_q <= shift_q[GS_SR_LEN-1];
    end
  end

  // Latching mid-cycle is allowed; outputs may glitch as the new values apply at once
  always_ff @(posedge clk) begin
    if (reset) begin
      gs_latch_q <= '0;
    end else if (latch_rise && !dc_mode) begin
      gs_latch_q <= shift_q;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dc_latch_q <= '0;
    end else if (latch_rise && dc_mode) begin
      dc_latch_q <= shift_q[DC_SR_LEN-1:0];
    end
  end

  // Grayscale counter
  always_ff @(posedge clk) begin
    if (reset) begin
      gs_count_q <= GS_ZERO;
    end else if (inhibit) begin
      gs_count_q <= GS_ZERO;
    end else if (pwm_rise && gs_count_q != GS_MAX) begin
      gs_count_q <= gs_count_q + GS_ONE;
    end
  end

  logic check_rise;
  logic check_fall;
  assign check_rise = pwm_rise && !inhibit && (gs_count_q == CHECK_COUNT - GS_ONE);
  assign check_fall = pwm_fall && !inhibit && (gs_count_q == CHECK_COUNT);

  logic [CHANNELS-1:0] on_at_check;
  logic [CHANNELS-1:0] compare_on;

  always_comb begin
    on_at_check = '0;
    compare_on  = '0;
    for (int ch = 0; ch < CHANNELS; ch++) begin
      // A channel counts as on at the check edge if its value covers the new count
      on_at_check[ch] = (gs_latch_q[ch*GS_BITS +: GS_BITS] >= CHECK_COUNT)
                        && !off_mask_q[ch];
      compare_on[ch]  = !inhibit && (gs_count_q != GS_ZERO) && (gs_count_q != GS_MAX)
                        && (gs_count_q <= gs_latch_q[ch*GS_BITS +: GS_BITS])
                        && !off_mask_q[ch];
    end
  end

  // Unchecked channels report normal, since no open condition can be seen on them
  always_ff @(posedge clk) begin
    if (reset) begin
      open_flag_q <= '0;
    end else if (check_rise) begin
      open_flag_q <= on_at_check & open_level;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      off_mask_q <= '0;
    end else if (inhibit) begin
      off_mask_q <= '0;
    end else if (check_fall && ctrl_q[CTRL_AUTO_OFF]) begin
      off_mask_q <= off_mask_q | open_flag_q;
    end
  end

  // A detector assertion in the clearing cycle keeps the flag set
  always_ff @(posedge clk) begin
    if (reset) begin
      overtemp_flag_q <= 1'b0;
    end else if (overtemp_level) begin
      overtemp_flag_q <= 1'b1;
    end else if (tef_clear_pending_q && shift_fall) begin
      overtemp_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      error_q <= 1'b0;
    end else begin
      error_q <= overtemp_flag_q | ((|open_flag_q) & ~inhibit);
    end
  end

  // Open drain: only ever pull low
  assign error_flag_n_o  = 1'b0;
  assign error_flag_n_oe = error_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      raw_on_q <= '0;
    end else begin
      raw_on_q <= compare_on;
    end
  end

  // Stagger delay lines; a short enable window still plays out after inhibit rises
  logic [DELAY_LEN-1:0] delay_q [CHANNELS];

  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    localparam int GROUP = ch % GROUPS;
    always_ff @(posedge clk) begin
      if (reset) begin
        delay_q[ch] <= '0;
      end else begin
        delay_q[ch] <= {delay_q[ch][DELAY_LEN-2:0], raw_on_q[ch]};
      end
    end
    if (GROUP == 0) begin : g_first
      assign channel_output[ch] = raw_on_q[ch];
    end else begin : g_later
      assign channel_output[ch] = delay_q[ch][GROUP*STAGGER_CYCLES-1];
    end
  end

  assign serial_out     = serial_out_q;
  assign dot_correction = dc_latch_q;

  // AHB-Lite slave, zero wait states
  logic                 addr_phase;
  logic                 wr_pend_q;
  logic [ADDR_BITS-1:0] wr_addr_q;
  logic [31:0]          rdata_q;
  logic [31:0]          read_mux;
  logic [31:0]          ctrl_view;

  assign addr_phase = ahb_req.hsel && ahb_req.htrans[HTRANS_ACTIVE] && ahb_req.hready;

  // Bypass so a read right after a control write sees the new value
  assign ctrl_view = (wr_pend_q && wr_addr_q == ADDR_CTRL)
                     ? (ahb_req.hwdata & CTRL_MASK) : ctrl_q;

  always_comb begin
    read_mux = READ_ZERO;
    if (ahb_req.haddr[ADDR_BITS-1:0] == ADDR_CTRL) begin
      read_mux = ctrl_view;
    end else if (ahb_req.haddr[ADDR_BITS-1:0] == ADDR_STATUS) begin
      read_mux = {{(32-STATUS_LEN){1'b0}}, status_word};
    end else if (ahb_req.haddr[ADDR_BITS-1:0] == ADDR_OUTPUTS) begin
      read_mux = {{(32-GS_BITS-CHANNELS){1'b0}}, gs_count_q, channel_output};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end else begin
      wr_pend_q <= addr_phase && ahb_req.hwrite;
      if (addr_phase) begin
        wr_addr_q <= ahb_req.haddr[ADDR_BITS-1:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= READ_ZERO;
    end else if (addr_phase && !ahb_req.hwrite) begin
      rdata_q <= read_mux;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_pend_q && wr_addr_q == ADDR_CTRL) begin
      ctrl_q <= ahb_req.hwdata & CTRL_MASK;
    end
  end

  assign ahb_rsp.hrdata    = rdata_q;
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp     = HRESP_OKAY;

endmodule : led_status_serial

/* hdl/led_driver_pkg.sv */
// Constants, register map and bus carriers for the LED driver status and serial control block
package led_driver_pkg;

  // Channel and shift register geometry
  localparam int CHANNELS    = 16;
  localparam int GROUPS      = 4;
  localparam int GS_BITS     = 12;
  localparam int DC_BITS     = 6;
  localparam int GS_SR_LEN   = 192;
  localparam int DC_SR_LEN   = 96;
  localparam int STATUS_LEN  = 17;
  localparam int STATUS_LSB  = GS_SR_LEN - STATUS_LEN;

  // Grayscale counter
  localparam logic [GS_BITS-1:0] GS_ZERO     = 12'h000;
  localparam logic [GS_BITS-1:0] GS_ONE      = 12'h001;
  localparam logic [GS_BITS-1:0] GS_MAX      = 12'hfff;
  localparam logic [GS_BITS-1:0] CHECK_COUNT = 12'h021;

  // Inter-group stagger, a least time rounded up to whole cycles
  localparam int CLK_MHZ        = 200;
  localparam int STAGGER_NS     = 20;
  localparam int STAGGER_CYCLES = (STAGGER_NS * CLK_MHZ + 999) / 1000;
  localparam int DELAY_LEN      = (GROUPS - 1) * STAGGER_CYCLES;

  // Register map (byte addresses, low address bits only are decoded)
  localparam int             ADDR_BITS      = 8;
  localparam logic [7:0]     ADDR_CTRL      = 8'h00;
  localparam logic [7:0]     ADDR_STATUS    = 8'h04;
  localparam logic [7:0]     ADDR_OUTPUTS   = 8'h08;
  localparam int             CTRL_AUTO_OFF  = 0;
  localparam logic [31:0]    CTRL_RESET     = 32'h0000_0001;
  localparam logic [31:0]    CTRL_MASK      = 32'h0000_0001;
  localparam logic [31:0]    READ_ZERO      = 32'h0000_0000;
  localparam logic           HRESP_OKAY     = 1'b0;
  localparam int             HTRANS_ACTIVE  = 1;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } ahb_rsp_t;

  // Bit order of the status word as it lands in the top of the shift register
  typedef struct packed {
    logic                overtemp;
    logic [CHANNELS-1:0] open_led;
  } status_word_t;

endpackage : led_driver_pkg

/* hdl/pin_sync.sv */
// Two-flop synchroniser with edge detection for a group of pins
`timescale 1ns/10ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] rise,
  output logic      [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] prev_q;

  // The first stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;
  assign fall  = ~sync_q & prev_q;

endmodule : pin_sync

/* sim/led_status_checker_assertions.sv */
// Concurrent checks on the LED driver status and serial control ports
`timescale 1ns/10ps
module led_status_checker
  import led_driver_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 reset,
  input wire ahb_req_t             ahb_req,
  input wire ahb_rsp_t             ahb_rsp,
  input wire logic                 shift_clock,
  input wire logic                 serial_in,
  input wire logic                 latch_strobe,
  input wire logic                 input_select,
  input wire logic                 pwm_clock,
  input wire logic                 output_inhibit,
  input wire logic [CHANNELS-1:0]  open_detect,
  input wire logic                 overtemp_detect,
  input wire logic                 serial_out,
  input wire logic                 error_flag_n_o,
  input wire logic                 error_flag_n_oe,
  input wire logic [CHANNELS-1:0]  channel_output,
  input wire logic [DC_SR_LEN-1:0] dot_correction
);
  logic [5:0] inh_q, ot_q, sr_q, sf_q, sel_q, lat_q;
  logic       sclk_q, sel_prev_q, lat_prev_q;

  // Cycles since an event; saturates so a long idle never wraps round
  function automatic logic [5:0] age(input logic hit, input logic [5:0] v);
    return hit ? 6'h00 : ((v == 6'h3f) ? v : v + 6'h01);
  endfunction : age

  always_ff @(posedge clk) begin
    if (reset) begin
      {inh_q, ot_q, sr_q, sf_q, sel_q, lat_q} <= '0;
      {sclk_q, sel_prev_q, lat_prev_q} <= '0;
    end else begin
      sclk_q <= shift_clock;
      sel_prev_q <= input_select;
      lat_prev_q <= latch_strobe;
      inh_q <= age(!output_inhibit, inh_q);
      ot_q <= age(overtemp_detect, ot_q);
      sr_q <= age(shift_clock && !sclk_q, sr_q);
      sf_q <= age(!shift_clock && sclk_q, sf_q);
      sel_q <= age(input_select != sel_prev_q, sel_q);
      lat_q <= age(latch_strobe && !lat_prev_q, lat_q);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  bus_okay_a: assert property (ahb_rsp.hreadyout && ahb_rsp.hresp == HRESP_OKAY)
    else $error("bus answer not ready or not okay");
  err_drive_low_a: assert property (error_flag_n_o == 1'b0)
    else $error("error pin driven high");
  hot_pulls_err_a: assert property (overtemp_detect [*6] |-> error_flag_n_oe)
    else $error("overtemp does not pull error low");
  open_masked_a: assert property (
    inh_q > 6'd20 && $rose(error_flag_n_oe) |-> ot_q < 6'd12)
    else $error("error raised by open flag while inhibited");
  hot_sticky_a: assert property (
    inh_q > 6'd20 && $fell(error_flag_n_oe) |-> sf_q < 6'd12)
    else $error("overtemp flag cleared without shift fall");
  inhibit_off_a: assert property (inh_q > 6'd30 |-> channel_output == '0)
    else $error("channel on while inhibited");
  serial_out_shift_a: assert property (
    $changed(serial_out) |-> sr_q < 6'd12 || sel_q < 6'd12)
    else $error("serial out moved without shift edge");
  dc_latch_a: assert property ($changed(dot_correction) |-> lat_q < 6'd12)
    else $error("dot correction changed without latch");
endmodule : led_status_checker

/* sim/link_ctl_model.sv */
// Controller model on the far side of the serial link
`timescale 1ns/10ps
module link_ctl_model (
  input  wire logic        serial_out,
  output logic             shift_clock,
  output logic             serial_in,
  output logic             latch_strobe,
  output logic [16:0]      status,
  output logic             done
);
  initial begin
    shift_clock = 1'b0;
    serial_in = 1'b0;
    latch_strobe = 1'b0;
    status = '0;
    done = 1'b0;
  end

  // Strobe stays low outside this pulse, so a mode change never races it
  task automatic strobe();
    #64 latch_strobe = 1'b1;
    #64 latch_strobe = 1'b0;
    #64;
  endtask : strobe

  task automatic send(input logic [191:0] frame);
    for (int i = 191; i >= 0; i--) begin
      serial_in = frame[i];
      #32 shift_clock = 1'b1;
      #32 shift_clock = 1'b0;
    end
    serial_in = ~serial_in;
    strobe();
  endtask : send

  task automatic read_status();
    strobe();
    for (int i = 16; i >= 0; i--) begin
      shift_clock = 1'b1;
      #32 status[i] = serial_out;
      shift_clock = 1'b0;
      #32;
    end
    done = 1'b1;
    #5 done = 1'b0;
  endtask : read_status
endmodule : link_ctl_model

/* sim/tb_led_status_serial.sv */
// Self-checking bench for the LED driver status and serial control block
`timescale 1ns/10ps
module tb_led_status_serial
  import led_driver_pkg::*;
;
  logic         clk, reset, shift_clock, serial_in, latch_strobe, input_select, done;
  logic         pwm_clock, output_inhibit, overtemp_detect, serial_out, rd_pend;
  logic         error_flag_n_o, error_flag_n_oe, hsel, hwrite;
  logic [1:0]   htrans;
  logic [31:0]  haddr, hwdata;
  logic [15:0]  open_detect, channel_output, exp_open;
  logic [16:0]  status;
  logic [95:0]  dot_correction, dc_val;
  logic [191:0] frame;
  ahb_req_t     ahb_req;
  ahb_rsp_t     ahb_rsp;
  logic [95:0]  exp_q[$];
  int           num_errors, tests_run, seed;
  event         look_err, look_out;

  assign ahb_req = {hsel, haddr, htrans, hwrite, 3'b010, hwdata, ahb_rsp.hreadyout};

  led_status_serial u_dut (.clk, .reset, .ahb_req, .ahb_rsp, .shift_clock, .serial_in,
    .latch_strobe, .input_select, .pwm_clock, .output_inhibit, .open_detect,
    .overtemp_detect, .serial_out, .error_flag_n_o, .error_flag_n_oe, .channel_output,
    .dot_correction);
  link_ctl_model u_ctl (.serial_out, .shift_clock, .serial_in, .latch_strobe, .status,
    .done);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic stop_test();
    $display("Checks run %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic check(input logic [95:0] got);
    logic [95:0] want;
    tests_run++;
    want = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
    if (want !== got) begin
      num_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, want, got);
    end
  endtask : check

  task automatic note(input logic [95:0] v);
    exp_q.push_back(v);
  endtask : note

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic pulses(input int n);
    repeat (n) begin
      pwm_clock <= 1'b1;
      cyc(4);
      pwm_clock <= 1'b0;
      cyc(4);
    end
  endtask : pulses

  task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    int k;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, addr};
    repeat (2) begin
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (ahb_rsp.hreadyout !== 1'b1 && k < 50);
      if (k == 50) begin
        num_errors++;
        stop_test();
      end
      htrans <= 2'b00;
      hwdata <= data;
    end
  endtask : ahb

  // Read data is taken at the edge that closes the data phase
  always @(posedge clk) begin
    if (ahb_rsp.hreadyout === 1'b1) begin
      if (rd_pend) check(96'(ahb_rsp.hrdata));
      rd_pend <= hsel && htrans[1] && !hwrite;
    end
  end
  always @(posedge done) check(96'(status));
  // Both probes are fired while the watched pin has stood still for cycles
  always @(look_err) check(96'(error_flag_n_oe));
  always @(look_out) check(96'(channel_output));
  always @(dot_correction) if (reset === 1'b0) check(dot_correction);

  initial begin
    #300000;
    num_errors++;
    stop_test();
  end

  initial begin
    seed = 32'h9749b2df;
    {reset, output_inhibit} = 2'b11;
    {hsel, hwrite, htrans, haddr, hwdata, open_detect} = '0;
    {pwm_clock, input_select, overtemp_detect, rd_pend} = '0;
    for (int n = 0; n < CHANNELS; n++) frame[n*12 +: 12] = 12'h019 + 12'(n);
    // Channel 0 plays a faulty LED, so the controller zeroes its grayscale
    frame[11:0] = 12'h000;
    cyc(16);
    reset <= 1'b0;
    note(96'(CTRL_RESET));
    ahb(1'b0, ADDR_CTRL, 32'h0);
    note(96'(READ_ZERO));
    ahb(1'b0, ADDR_STATUS, 32'h0);
    ahb(1'b1, 8'h0c, 32'hffffffff);
    note(96'(READ_ZERO));
    ahb(1'b0, 8'h0c, 32'h0);
    input_select <= 1'b1;
    cyc(8);
    dc_val = {$random(seed), $random(seed), $random(seed)};
    note(dc_val);
    u_ctl.send({96'h0, dc_val});
    @(posedge clk);
    input_select <= 1'b0;
    cyc(8);
    u_ctl.send(frame);
    for (int m = 1; m >= 0; m--) begin
      ahb(1'b1, ADDR_CTRL, 32'(m));
      open_detect <= 16'($random(seed)) | 16'h0001;
      cyc(8);
      exp_open = open_detect & 16'hff00;
      output_inhibit <= 1'b0;
      cyc(8);
      pulses(1);
      cyc(2);
      // Groups 0 and 1 are on except channel 0, groups 2 and 3 still wait out their stagger
      note(96'(16'h3332));
      -> look_out;
      pulses(33);
      cyc(24);
      note(96'(|exp_open));
      -> look_err;
      note(96'(exp_open));
      ahb(1'b0, ADDR_STATUS, 32'h0);
      note(96'({4'h0, 12'h022, 16'hfe00 & ~((m == 1) ? exp_open : 16'h0)}));
      ahb(1'b0, ADDR_OUTPUTS, 32'h0);
      output_inhibit <= 1'b1;
      cyc(10);
      // Groups 0 and 1 are already off; channels 10, 11, 14 and 15 of groups 2 and 3 stay on unless switched off as open
      note(96'(16'hcc00 & ~((m == 1) ? exp_open : 16'h0)));
      -> look_out;
      cyc(20);
      note(96'h0);
      -> look_err;
      note(96'h0);
      ahb(1'b0, ADDR_OUTPUTS, 32'h0);
    end
    overtemp_detect <= 1'b1;
    cyc(20);
    overtemp_detect <= 1'b0;
    cyc(20);
    note(96'h1);
    -> look_err;
    note(96'({1'b1, exp_open}));
    ahb(1'b0, ADDR_STATUS, 32'h0);
    note(96'({1'b1, exp_open}));
    u_ctl.read_status();
    note(96'({1'b0, exp_open}));
    ahb(1'b0, ADDR_STATUS, 32'h0);
    note(96'h0);
    -> look_err;
    cyc(1);
    stop_test();
  end
endmodule : tb_led_status_serial

bind led_status_serial led_status_checker u_chk (.clk, .reset, .ahb_req, .ahb_rsp,
  .shift_clock, .serial_in, .latch_strobe, .input_select, .pwm_clock, .output_inhibit,
  .open_detect, .overtemp_detect, .serial_out, .error_flag_n_o, .error_flag_n_oe,
  .channel_output, .dot_correction);
